// ### hw/adc_ctrl_defs.svh
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH
`define ADDR_OPTION 8'h94
`define ADDR_INT_FLAGS 8'h95
`define ADDR_RES_LO 8'haa
`define ADDR_RES_HI 8'hab
`define ADDR_CHANNEL_SEL 8'hae
`define ADDR_AUX_CTRL 8'hf8
`define ADDR_IRQ_ENABLE 8'hb0
`define ADDR_IRQ_STATUS 8'hb1
`define ADDR_IRQ_CLEAR 8'hb2
`define DIV_MSB 3
`define DIV_LSB 2
`define DONE_BIT 4
`define START_BIT 4
`define BYPASS_BIT 2
`define CH_MSB 7
`define CH_LSB 4
`define CHANNEL_SELECT_REG_RESET 4'hf
`define CONV_CYCLES 6'h32
`define CH_LAST_EXT 4'hb
`define CH_REF 4'hc
`define CH_REF_BUF 4'hd
`define CH_GND 4'he
`endif

// ### hw/adc_ctrl_pkg.sv
// Types shared by the converter control
package adc_ctrl_pkg;
    typedef enum logic [1:0] {
        DIV_32,
        DIV_16,
        DIV_8,
        DIV_4
    } clk_div_t;
    typedef enum logic [1:0] {
        SRC_EXTERNAL,
        SRC_REF,
        SRC_REF_BUF,
        SRC_GROUND
    } mux_src_t;
endpackage : adc_ctrl_pkg

// ### hw/adc_conversion_control.sv
// Converter control: clock divider, start/done sequencing, result registers, channel mux
// Notes on behaviour
// - converter clock is system clock divided by 32, 16, 8 or 4 per select.
// - writing one to the start bit begins conversion; hardware clears it at end.
// - end of conversion sets the done flag; interrupt raised when enabled.
// - done flag clears on a zero write or on writing one to start.
// - a conversion lasts 50 converter clock cycles.
// - result registers load together with the done flag.
// - high register holds bits 11..4; low register bits 7..4 hold bits 3..0.
// - channel codes 0..11 select external inputs zero to eleven.
// - code 12 internal reference, 13 buffered reference, 14 ground.
// - bypass bit zero routes through the op-amp; one bypasses it.
// - software may also clear the start bit by writing zero.
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_defs.svh"
module adc_conversion_control #(
    parameter int RES_BITS = 12
) (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Converter core
    input wire logic [RES_BITS-1:0] core_result,
    output logic conv_clk_tick,
    output logic conv_busy,
    output logic [3:0] analog_input_pins_sel,
    output logic analog_input_en,
    output adc_ctrl_pkg::mux_src_t mux_source,
    output logic opamp_bypass_sel,
    // Interrupt
    output logic irq
);
    import adc_ctrl_pkg::*;

    // The split into high byte and low nibble is wired for twelve bits only
    if (RES_BITS != 12) begin : g_res_bits_check
        $error("adc_conversion_control supports only a 12-bit result");
    end

    // Software-visible state
    clk_div_t conv_clock_divider_sel_reg;
    clk_div_t conv_clock_divider_sel_next;
    logic conv_start_bit_reg;
    logic conv_start_bit_next;
    logic conv_done_flag_reg;
    logic conv_done_flag_next;
    logic opamp_bypass_sel_reg;
    logic opamp_bypass_sel_next;
    logic [3:0] input_channel_sel_reg;
    logic [3:0] input_channel_sel_next;
    logic [7:0] result_high_byte_reg;
    logic [7:0] result_high_byte_next;
    logic [3:0] result_low_nibble_reg;
    logic [3:0] result_low_nibble_next;
    logic irq_enable_reg;
    logic irq_enable_next;
    logic irq_status_reg;
    logic irq_status_next;
    // Conversion engine
    logic [4:0] div_cnt_reg;
    logic [4:0] div_cnt_next;
    logic [5:0] cyc_cnt_reg;
    logic [5:0] cyc_cnt_next;
    logic tick_reg;
    logic tick_next;
    // Outputs
    logic [7:0] reg_rdata_next;
    logic irq_next;
    logic [3:0] pins_sel_next;
    logic input_en_next;
    mux_src_t mux_source_next;

    // Decoded strobes and the prescaler terminal count
    logic [4:0] div_top;
    logic wr_aux;
    logic wr_flg;
    logic wr_option;
    logic wr_channel_select_reg;
    logic wr_irq_en;
    logic wr_irq_clr;
    logic start_wr;
    logic conv_end;

    // Terminal count of the prescaler; every select code is legal
    always_comb begin
        unique case (conv_clock_divider_sel_reg)
            DIV_32: div_top = 5'h1f;
            DIV_16: div_top = 5'h0f;
            DIV_8: div_top = 5'h07;
            DIV_4: div_top = 5'h03;
        endcase
    end

    // Register decode, shared by the configuration, conversion and engine groups below; the read path decodes the address itself
    always_comb begin
        wr_aux = reg_wr && (reg_addr == `ADDR_AUX_CTRL);
        wr_flg = reg_wr && (reg_addr == `ADDR_INT_FLAGS);
        wr_option = reg_wr && (reg_addr == `ADDR_OPTION);
        wr_channel_select_reg = reg_wr && (reg_addr == `ADDR_CHANNEL_SEL);
        wr_irq_en = reg_wr && (reg_addr == `ADDR_IRQ_ENABLE);
        wr_irq_clr = reg_wr && (reg_addr == `ADDR_IRQ_CLEAR) && reg_wdata[`DONE_BIT];
        start_wr = wr_aux && reg_wdata[`START_BIT];
        // Last converter clock edge of the 50 ends the conversion
        conv_end = conv_start_bit_reg && tick_reg && (cyc_cnt_reg == `CONV_CYCLES - 6'h01);
    end

    // Configuration group: written by software only
    always_comb begin
        conv_clock_divider_sel_next = conv_clock_divider_sel_reg;
        opamp_bypass_sel_next = opamp_bypass_sel_reg;
        input_channel_sel_next = input_channel_sel_reg;
        irq_enable_next = irq_enable_reg;
        // A new divider applies at once to the running prescaler count, even mid-conversion
        if (wr_option) begin
            conv_clock_divider_sel_next = clk_div_t'(reg_wdata[`DIV_MSB:`DIV_LSB]);
        end
        if (wr_channel_select_reg) begin
            input_channel_sel_next = reg_wdata[`CH_MSB:`CH_LSB];
        end
        if (wr_irq_en) begin
            irq_enable_next = reg_wdata[`DONE_BIT];
        end
        if (wr_aux) begin
            opamp_bypass_sel_next = reg_wdata[`BYPASS_BIT];
        end
    end

    // Conversion group: start bit, done flag, interrupt status and results
    always_comb begin
        conv_start_bit_next = conv_start_bit_reg;
        conv_done_flag_next = conv_done_flag_reg;
        irq_status_next = irq_status_reg;
        result_high_byte_next = result_high_byte_reg;
        result_low_nibble_next = result_low_nibble_reg;
        if (wr_aux) begin
            conv_start_bit_next = reg_wdata[`START_BIT];
        end else if (conv_end) begin
            conv_start_bit_next = 1'b0;
        end
        // Zero write to the flag, or a start write, clears it; writing one has no effect
        if ((wr_flg && !reg_wdata[`DONE_BIT]) || start_wr) begin
            conv_done_flag_next = 1'b0;
        end
        if (wr_irq_clr) begin
            irq_status_next = 1'b0;
        end
        // Set after the clears so an end of conversion beats a same-cycle clear;
        // a control write in the final cycle aborts or restarts, so it loads nothing
        if (conv_end && !wr_aux) begin
            conv_done_flag_next = 1'b1;
            irq_status_next = 1'b1;
            result_high_byte_next = core_result[11:4];
            result_low_nibble_next = core_result[3:0];
        end
    end

    always_comb begin
        div_cnt_next = div_cnt_reg;
        cyc_cnt_next = cyc_cnt_reg;
        tick_next = 1'b0;
        // Prescaler runs only while converting, so the first tick is a full period after start
        if (!conv_start_bit_reg || start_wr) begin
            // Idle, or restart: counters begin fresh
            div_cnt_next = 5'h00;
            cyc_cnt_next = 6'h00;
        end else begin
            if (div_cnt_reg >= div_top) begin
                div_cnt_next = 5'h00;
                tick_next = 1'b1;
            end else begin
                div_cnt_next = div_cnt_reg + 5'h01;
            end
            if (tick_reg) begin
                cyc_cnt_next = cyc_cnt_reg + 6'h01;
            end
        end
    end

    // Zero outside the read slot, so a stale value never lingers on the bus
    always_comb begin
        reg_rdata_next = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                `ADDR_OPTION: reg_rdata_next[`DIV_MSB:`DIV_LSB] = conv_clock_divider_sel_reg;
                `ADDR_INT_FLAGS: reg_rdata_next[`DONE_BIT] = conv_done_flag_reg;
                `ADDR_RES_LO: reg_rdata_next[`CH_MSB:`CH_LSB] = result_low_nibble_reg;
                `ADDR_RES_HI: reg_rdata_next = result_high_byte_reg;
                `ADDR_CHANNEL_SEL: reg_rdata_next[`CH_MSB:`CH_LSB] = input_channel_sel_reg;
                `ADDR_AUX_CTRL: begin
                    reg_rdata_next[`START_BIT] = conv_start_bit_reg;
                    reg_rdata_next[`BYPASS_BIT] = opamp_bypass_sel_reg;
                end
                `ADDR_IRQ_ENABLE: reg_rdata_next[`DONE_BIT] = irq_enable_reg;
                `ADDR_IRQ_STATUS: reg_rdata_next[`DONE_BIT] = irq_status_reg;
                `ADDR_IRQ_CLEAR: reg_rdata_next = 8'h00;
                default: reg_rdata_next = 8'h00;
            endcase
        end
    end

    always_comb begin
        irq_next = irq_status_next && irq_enable_next;
        pins_sel_next = 4'h0;
        input_en_next = 1'b0;
        // Decoded from the next code so the mux follows a channel write with no extra cycle
        if (input_channel_sel_next <= `CH_LAST_EXT) begin
            mux_source_next = SRC_EXTERNAL;
            pins_sel_next = input_channel_sel_next;
            input_en_next = 1'b1;
        end else if (input_channel_sel_next == `CH_REF) begin
            mux_source_next = SRC_REF;
        end else if (input_channel_sel_next == `CH_REF_BUF) begin
            mux_source_next = SRC_REF_BUF;
        end else begin
            mux_source_next = SRC_GROUND;
        end
    end

    // Configuration group
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            conv_clock_divider_sel_reg <= DIV_32;
            opamp_bypass_sel_reg <= 1'b0;
            input_channel_sel_reg <= `CHANNEL_SELECT_REG_RESET;
            irq_enable_reg <= 1'b0;
        end else if (clk_en) begin
            conv_clock_divider_sel_reg <= conv_clock_divider_sel_next;
            opamp_bypass_sel_reg <= opamp_bypass_sel_next;
            input_channel_sel_reg <= input_channel_sel_next;
            irq_enable_reg <= irq_enable_next;
        end
    end

    // Conversion group
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            conv_start_bit_reg <= 1'b0;
            conv_done_flag_reg <= 1'b0;
            irq_status_reg <= 1'b0;
            result_high_byte_reg <= 8'h00;
            result_low_nibble_reg <= 4'h0;
        end else if (clk_en) begin
            conv_start_bit_reg <= conv_start_bit_next;
            conv_done_flag_reg <= conv_done_flag_next;
            irq_status_reg <= irq_status_next;
            result_high_byte_reg <= result_high_byte_next;
            result_low_nibble_reg <= result_low_nibble_next;
        end
    end

    // Engine group
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            div_cnt_reg <= 5'h00;
            cyc_cnt_reg <= 6'h00;
            tick_reg <= 1'b0;
        end else if (clk_en) begin
            div_cnt_reg <= div_cnt_next;
            cyc_cnt_reg <= cyc_cnt_next;
            tick_reg <= tick_next;
        end
    end

    // Output group: every port is a flop, loaded from the next values of its source
    // Busy follows the next start bit, so it rises with the start write itself
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 8'h00;
            irq <= 1'b0;
            analog_input_pins_sel <= 4'h0;
            analog_input_en <= 1'b0;
            mux_source <= SRC_GROUND;
            opamp_bypass_sel <= 1'b0;
            conv_clk_tick <= 1'b0;
            conv_busy <= 1'b0;
        end else if (clk_en) begin
            reg_rdata <= reg_rdata_next;
            irq <= irq_next;
            analog_input_pins_sel <= pins_sel_next;
            analog_input_en <= input_en_next;
            mux_source <= mux_source_next;
            opamp_bypass_sel <= opamp_bypass_sel_next;
            conv_clk_tick <= tick_next;
            conv_busy <= conv_start_bit_next;
        end
    end
endmodule : adc_conversion_control
`default_nettype wire

// ### testbench/adc_conversion_control_checker.sv
// Port-level assertions for the converter control
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_defs.svh"
module adc_conversion_control_checker #(
    parameter int RES_BITS = 12
) (
    input wire logic sys_clk, reset, clk_en, reg_wr, reg_rd,
    input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
    input wire logic [RES_BITS-1:0] core_result,
    input wire logic conv_clk_tick, conv_busy, analog_input_en, opamp_bypass_sel, irq,
    input wire logic [3:0] analog_input_pins_sel,
    input wire adc_ctrl_pkg::mux_src_t mux_source
);
    import adc_ctrl_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_rdata_idle: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    a_tick_idle: assert property (!conv_busy && !$past(conv_busy) |-> !conv_clk_tick)
        else $error("tick while idle");
    a_tick_gap: assert property (conv_clk_tick |=> !conv_clk_tick [*3])
        else $error("ticks closer than four cycles");
    a_ext_range: assert property (analog_input_en |-> mux_source == SRC_EXTERNAL && analog_input_pins_sel <= 4'hb)
        else $error("external select out of range");
    a_nonext_zero: assert property (!analog_input_en |-> analog_input_pins_sel == 4'h0 && mux_source != SRC_EXTERNAL)
        else $error("pin select while not external");
    a_ref_select: assert property (clk_en && reg_wr && reg_addr == `ADDR_CHANNEL_SEL && reg_wdata[7:4] == `CH_REF
        |-> ##[1:2] mux_source == SRC_REF)
        else $error("reference not selected");
    a_start_busy: assert property (clk_en && reg_wr && reg_addr == 8'hf8 && reg_wdata[4] |=> conv_busy)
        else $error("start write did not start");
    a_stop_idle: assert property (clk_en && reg_wr && reg_addr == 8'hf8 && !reg_wdata[4] |=> !conv_busy)
        else $error("zero write did not stop");
endmodule : adc_conversion_control_checker
bind adc_conversion_control adc_conversion_control_checker #(.RES_BITS(RES_BITS)) chk (
    .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .core_result(core_result),
    .conv_clk_tick(conv_clk_tick), .conv_busy(conv_busy), .analog_input_en(analog_input_en),
    .opamp_bypass_sel(opamp_bypass_sel), .irq(irq), .analog_input_pins_sel(analog_input_pins_sel),
    .mux_source(mux_source));
`default_nettype wire

// ### testbench/adc_conversion_control_tb.sv
// Self-checking bench for the converter control
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_defs.svh"
module adc_conversion_control_tb;
    import adc_ctrl_pkg::*;
    logic sys_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [11:0] core_result = 12'h000, res;
    logic conv_clk_tick, conv_busy, analog_input_en, opamp_bypass_sel, irq;
    logic [3:0] analog_input_pins_sel;
    mux_src_t mux_source;
    logic [31:0] seed = 32'h646f;
    int errors = 0, checks_done = 0, n;
    adc_conversion_control dut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .core_result(core_result), .conv_clk_tick(conv_clk_tick),
        .conv_busy(conv_busy), .analog_input_pins_sel(analog_input_pins_sel),
        .analog_input_en(analog_input_en), .mux_source(mux_source),
        .opamp_bypass_sel(opamp_bypass_sel), .irq(irq));
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    // Packed as {0, enable, pin select, source}
    function automatic logic [7:0] exp_mux(input logic [3:0] c);
        if (c <= 4'hb) return {2'h1, c, 2'h0};
        return {6'h00, c == 4'hc ? 2'h1 : c == 4'hd ? 2'h2 : 2'h3};
    endfunction : exp_mux
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk(reg_rdata, exp);
    endtask : rd
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run
    initial begin
        #(40 * 20000);
        errors++;
        complete_run();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        rd(`ADDR_CHANNEL_SEL, 8'hf0);
        rd(`ADDR_INT_FLAGS, 8'h00);
        rd(8'h55, 8'h00);
        chk({6'h00, mux_source}, 8'h03);
        $display("reset test done");
        for (int c = 0; c < 16; c++) begin
            seed = xs(seed);
            wr(`ADDR_CHANNEL_SEL, {c[3:0], seed[3:0]});
            repeat (2) @(negedge sys_clk);
            chk({1'b0, analog_input_en, analog_input_pins_sel, mux_source}, exp_mux(c[3:0]));
        end
        // Writes while frozen must be ignored
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr(`ADDR_CHANNEL_SEL, 8'h30);
        clk_en <= 1'b1;
        repeat (2) @(negedge sys_clk);
        chk({1'b0, analog_input_en, analog_input_pins_sel, mux_source}, exp_mux(4'hf));
        wr(8'hf8, 8'h04);
        repeat (2) @(negedge sys_clk);
        chk({7'h00, opamp_bypass_sel}, 8'h01);
        wr(8'hf8, 8'h00);
        repeat (2) @(negedge sys_clk);
        chk({7'h00, opamp_bypass_sel}, 8'h00);
        $display("channel test done");
        wr(`ADDR_IRQ_ENABLE, 8'h10);
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            res = seed[11:0];
            core_result <= res;
            if (k == 2) wr(`ADDR_INT_FLAGS, 8'hef);
            wr(`ADDR_OPTION, {4'h0, k[1:0], 2'h0});
            rd(`ADDR_OPTION, {4'h0, k[1:0], 2'h0});
            wr(8'hf8, 8'h10);
            rd(`ADDR_INT_FLAGS, 8'h00);
            n = 3;
            do begin
                @(negedge sys_clk);
                n++;
            end while (conv_busy === 1'b1 && n < 2000);
            chk({7'h00, n >= 50 * (32 >> k) && n <= 50 * (32 >> k) + 3}, 8'h01);
            rd(8'hf8, 8'h00);
            rd(`ADDR_INT_FLAGS, 8'h10);
            rd(`ADDR_RES_HI, res[11:4]);
            rd(`ADDR_RES_LO, {res[3:0], 4'h0});
            chk({7'h00, irq}, 8'h01);
        end
        wr(`ADDR_IRQ_ENABLE, 8'h00);
        repeat (2) @(negedge sys_clk);
        chk({7'h00, irq}, 8'h00);
        wr(`ADDR_IRQ_ENABLE, 8'h10);
        rd(`ADDR_IRQ_STATUS, 8'h10);
        chk({7'h00, irq}, 8'h01);
        wr(`ADDR_IRQ_CLEAR, 8'h10);
        repeat (2) @(negedge sys_clk);
        chk({7'h00, irq}, 8'h00);
        $display("conversion test done");
        core_result <= ~res;
        wr(8'hf8, 8'h10);
        repeat (100) @(posedge sys_clk);
        wr(8'hf8, 8'h00);
        repeat (250) @(negedge sys_clk);
        rd(`ADDR_INT_FLAGS, 8'h00);
        rd(`ADDR_RES_HI, res[11:4]);
        $display("abort test done");
        complete_run();
    end
endmodule : adc_conversion_control_tb
`default_nettype wire
